// ===== src/pmwc_top.sv
/*
 Power mode, clock switch and wake-up controller with an APB register slave.
 Assumes the core halts on cpu_run low and samples wake reasons on wake_pulse.
*/
// Design decisions made here: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
module pmwc_top #(
	parameter int PA_W = 8,
	parameter int IRQ_W = 8,
	parameter int WDT_W = 16
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [PA_W-1:0] porta_in,
	input wire logic [IRQ_W-1:0] irq_req,
	input wire logic [IRQ_W-1:0] irq_en,
	input wire logic stack_full,
	input wire logic halt_req,
	input wire logic clr_wdt,
	output logic cpu_run,
	output logic [2:0] sysclk_div_sel,
	output logic sysclk_slow,
	output logic hs_osc_on,
	output logic ls_osc_on,
	output logic wdt_overflow,
	output logic pc_sp_reset,
	output logic irq_take,
	output logic wake_pulse
);
	import pmwc_pkg::*;

	pmwc_state_t state_q;
	logic [2:0] sysclk_select_q;
	logic hs_osc_halt_keep_q, ls_osc_halt_keep_q, hs_osc_enable_q, hs_osc_stable_flag_q;
	logic ls_stable_q, wdt_en_q, power_down_flag_q, watchdog_timeout_flag_q;
	logic [PA_W-1:0] porta_wake_enable_q, porta_prev_q;
	logic [IRQ_W-1:0] irq_block_q;
	logic [7:0] hs_cnt_q, ls_cnt_q;
	logic [WDT_W-1:0] wdt_q;
	logic wr, rd, halt_go, cmd_halt, cmd_clr, in_halt, wake_port, wake_irq, wake_wdt;
	logic [31:0] rdata_d;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
		return a == r;
	endfunction

	assign wr = psel && penable && pwrite;
	assign rd = psel && penable && !pwrite;
	assign cmd_halt = wr && hit(paddr, PMWC_ADDR_CMD) && pwdata[PMWC_CMD_HALT_BIT];
	assign cmd_clr = clr_wdt || (wr && hit(paddr, PMWC_ADDR_CMD) && pwdata[PMWC_CMD_CLRWDT_BIT]);
	assign halt_go = (state_q == PMWC_RUN) && (halt_req || cmd_halt);
	assign in_halt = (state_q != PMWC_RUN) && (state_q != PMWC_WAKE);
	// Falling edge on enabled pin
	assign wake_port = |(porta_prev_q & ~porta_in & porta_wake_enable_q);
	// Requests already pending at halt are masked
	assign wake_irq = |(irq_req & ~irq_block_q);
	assign wake_wdt = wdt_en_q && (&wdt_q);

	// APB slave, zero wait
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0;
		end else begin
			pready <= psel && !penable;
			pslverr <= 1'b0;
			if (psel && !penable && !pwrite)
				prdata <= rdata_d;
			if (psel && !penable && !(hit(paddr, PMWC_ADDR_CLKCTL) || hit(paddr, PMWC_ADDR_HSCTL)
				|| hit(paddr, PMWC_ADDR_WAKEEN) || hit(paddr, PMWC_ADDR_STATUS)
				|| hit(paddr, PMWC_ADDR_CMD)))
				pslverr <= 1'b1;
		end
	end

	always_comb begin
		rdata_d = 32'h0;
		unique case (paddr)
			PMWC_ADDR_CLKCTL: begin
				rdata_d[PMWC_SEL_LSB +: 3] = sysclk_select_q;
				rdata_d[PMWC_HSKEEP_BIT] = hs_osc_halt_keep_q;
				rdata_d[PMWC_LSKEEP_BIT] = ls_osc_halt_keep_q;
			end
			PMWC_ADDR_HSCTL: begin
				rdata_d[PMWC_HSEN_BIT] = hs_osc_enable_q;
				rdata_d[PMWC_HSF_BIT] = hs_osc_stable_flag_q;
			end
			PMWC_ADDR_WAKEEN: rdata_d[PA_W-1:0] = porta_wake_enable_q;
			PMWC_ADDR_STATUS: rdata_d[4:0] = {wdt_en_q, ls_stable_q, watchdog_timeout_flag_q,
				power_down_flag_q, sysclk_slow};
			default: rdata_d = 32'h0;
		endcase
	end

	// Software controls; the write lands in the access cycle with pready
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sysclk_select_q <= PMWC_SEL_RST;
			hs_osc_halt_keep_q <= 1'b0;
			ls_osc_halt_keep_q <= 1'b0;
			hs_osc_enable_q <= PMWC_HSEN_RST;
			porta_wake_enable_q <= '0;
			wdt_en_q <= 1'b1;
		end else if (wr && pready) begin
			if (hit(paddr, PMWC_ADDR_CLKCTL)) begin
				sysclk_select_q <= pwdata[PMWC_SEL_LSB +: 3];
				hs_osc_halt_keep_q <= pwdata[PMWC_HSKEEP_BIT];
				ls_osc_halt_keep_q <= pwdata[PMWC_LSKEEP_BIT];
			end
			if (hit(paddr, PMWC_ADDR_HSCTL))
				hs_osc_enable_q <= pwdata[PMWC_HSEN_BIT];
			if (hit(paddr, PMWC_ADDR_WAKEEN))
				porta_wake_enable_q <= pwdata[PA_W-1:0];
			if (hit(paddr, PMWC_ADDR_CMD) && pwdata[PMWC_CMD_WDTEN_BIT])
				wdt_en_q <= 1'b1;
			if (hit(paddr, PMWC_ADDR_CMD) && pwdata[PMWC_CMD_WDTDIS_BIT])
				wdt_en_q <= 1'b0;
		end
	end

	// Mode machine
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= PMWC_RUN;
			irq_block_q <= '0;
			wake_pulse <= 1'b0;
			pc_sp_reset <= 1'b0;
			irq_take <= 1'b0;
			cpu_run <= 1'b1;
		end else begin
			wake_pulse <= 1'b0;
			pc_sp_reset <= 1'b0;
			irq_take <= 1'b0;
			unique case (state_q)
				PMWC_RUN: if (halt_go) begin
					irq_block_q <= irq_req;
					cpu_run <= 1'b0;
					unique case ({hs_osc_halt_keep_q, ls_osc_halt_keep_q})
						2'b00: state_q <= PMWC_SLEEP;
						2'b01: state_q <= PMWC_IDLE_SUB_ONLY;
						2'b11: state_q <= PMWC_IDLE_BOTH_CLOCKS;
						2'b10: state_q <= PMWC_IDLE_FAST_ONLY;
					endcase
				end
				PMWC_WAKE: if (sysclk_slow ? ls_stable_q : hs_osc_stable_flag_q) begin
					state_q <= PMWC_RUN;
					cpu_run <= 1'b1;
				end
				default: if (wake_port || wake_irq || wake_wdt) begin
					state_q <= PMWC_WAKE;
					wake_pulse <= 1'b1;
					pc_sp_reset <= wake_wdt;
					// Service only if enabled and room on stack
					irq_take <= !wake_wdt && |(irq_req & ~irq_block_q & irq_en) && !stack_full;
				end
			endcase
		end
	end

	// Status flags
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			power_down_flag_q <= 1'b0;
			watchdog_timeout_flag_q <= 1'b0;
		end else begin
			if (halt_go) begin
				power_down_flag_q <= 1'b1;
				watchdog_timeout_flag_q <= 1'b0;
			end else if (cmd_clr)
				power_down_flag_q <= 1'b0;
			if (in_halt && wake_wdt)
				watchdog_timeout_flag_q <= 1'b1;
		end
	end

	// Watchdog counter and overflow pulse
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wdt_q <= '0;
			wdt_overflow <= 1'b0;
		end else begin
			wdt_overflow <= wake_wdt && !in_halt;
			if (halt_go || cmd_clr || wake_wdt)
				wdt_q <= '0;
			else if (wdt_en_q && ls_osc_on)
				wdt_q <= wdt_q + 1'b1;
		end
	end

	// Oscillator gating and stabilisation
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hs_osc_on <= 1'b1;
			ls_osc_on <= 1'b1;
			hs_cnt_q <= '0;
			ls_cnt_q <= '0;
			hs_osc_stable_flag_q <= 1'b0;
			ls_stable_q <= 1'b0;
			sysclk_slow <= 1'b0;
			sysclk_div_sel <= PMWC_SEL_RST;
		end else begin
			// Fast oscillator: enable outside halt (slow mode honours enable), keep in halt
			hs_osc_on <= in_halt || halt_go ? (halt_go ? hs_osc_halt_keep_q :
				(state_q == PMWC_IDLE_BOTH_CLOCKS || state_q == PMWC_IDLE_FAST_ONLY)) :
				(hs_osc_enable_q || sysclk_select_q != PMWC_SEL_SLOW);
			// Slow oscillator held while watchdog runs
			ls_osc_on <= (in_halt || halt_go) ? (ls_osc_halt_keep_q || wdt_en_q) : 1'b1;
			// Stable flag drops while off, sets after count
			if (!hs_osc_on) begin
				hs_cnt_q <= '0;
				hs_osc_stable_flag_q <= 1'b0;
			end else if (hs_cnt_q == 8'(PMWC_HS_STABLE_CYC - 1))
				hs_osc_stable_flag_q <= 1'b1;
			else
				hs_cnt_q <= hs_cnt_q + 8'h01;
			if (!ls_osc_on) begin
				ls_cnt_q <= '0;
				ls_stable_q <= 1'b0;
			end else if (ls_cnt_q == 8'(PMWC_LS_STABLE_CYC - 1))
				ls_stable_q <= 1'b1;
			else
				ls_cnt_q <= ls_cnt_q + 8'h01;
			// Slow switch waits on subclock
			if (sysclk_select_q == PMWC_SEL_SLOW) begin
				if (ls_stable_q)
					sysclk_slow <= 1'b1;
			end else if (hs_osc_stable_flag_q) begin
				sysclk_slow <= 1'b0;
				sysclk_div_sel <= sysclk_select_q;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			porta_prev_q <= '0;
		else
			porta_prev_q <= porta_in;
	end
endmodule

// ===== src/pmwc_pkg.sv
/*
 Constants and types for the power mode and wake-up controller.
 Assumes an APB master on pclk and a core that reacts to halt and wake outputs.
*/
package pmwc_pkg;
	localparam logic [7:0] PMWC_ADDR_CLKCTL = 8'h00;
	localparam logic [7:0] PMWC_ADDR_HSCTL = 8'h04;
	localparam logic [7:0] PMWC_ADDR_WAKEEN = 8'h08;
	localparam logic [7:0] PMWC_ADDR_STATUS = 8'h0c;
	localparam logic [7:0] PMWC_ADDR_CMD = 8'h10;
	localparam int PMWC_SEL_LSB = 5;
	localparam int PMWC_HSKEEP_BIT = 1;
	localparam int PMWC_LSKEEP_BIT = 0;
	localparam int PMWC_HSEN_BIT = 0;
	localparam int PMWC_HSF_BIT = 1;
	localparam logic [2:0] PMWC_SEL_SLOW = 3'h7;
	localparam logic [2:0] PMWC_SEL_RST = 3'h0;
	localparam logic PMWC_HSEN_RST = 1'b1;
	localparam int PMWC_CMD_CLRWDT_BIT = 0;
	localparam int PMWC_CMD_HALT_BIT = 1;
	localparam int PMWC_CMD_WDTEN_BIT = 2;
	localparam int PMWC_CMD_WDTDIS_BIT = 3;
	localparam int PMWC_HS_STABLE_CYC = 64;
	localparam int PMWC_LS_STABLE_CYC = 16;
	typedef enum logic [2:0] {
		PMWC_RUN = 3'b000,
		PMWC_SLEEP = 3'b001,
		PMWC_IDLE_SUB_ONLY = 3'b010,
		PMWC_IDLE_BOTH_CLOCKS = 3'b011,
		PMWC_IDLE_FAST_ONLY = 3'b100,
		PMWC_WAKE = 3'b101
	} pmwc_state_t;
endpackage

// ===== tb/pmwc_assertions.sv
/*
 Port checker for the power mode controller.
 Assumes binding to pmwc_top on the single pclk domain.
*/
`timescale 1ns/1ps
module pmwc_assertions (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic halt_req,
	input wire logic cpu_run,
	input wire logic wake_pulse,
	input wire logic pc_sp_reset,
	input wire logic irq_take,
	input wire logic sysclk_slow,
	input wire logic ls_osc_on,
	input wire logic [2:0] sysclk_div_sel,
	input wire logic pready,
	input wire logic pslverr
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_halt_stops_core: assert property (halt_req && cpu_run |=> !cpu_run)
		else $error("core ran on after halt");
	a_wake_while_halted: assert property (wake_pulse |-> !cpu_run)
		else $error("wake while running");
	a_wake_single: assert property (wake_pulse |=> !wake_pulse)
		else $error("wake pulse too long");
	a_wdt_wake_pair: assert property (pc_sp_reset |-> wake_pulse)
		else $error("pc reset without wake");
	a_irq_wake_pair: assert property (irq_take |-> wake_pulse)
		else $error("interrupt taken without wake");
	a_resume_bound: assert property (wake_pulse |=> ##[0:100] cpu_run)
		else $error("core not resumed");
	a_slow_needs_sub: assert property ($rose(sysclk_slow) |-> ls_osc_on)
		else $error("slow clock without subclock");
	a_fast_div_range: assert property (!sysclk_slow |-> sysclk_div_sel != 3'h7)
		else $error("bad divider in fast mode");
	a_err_with_ready: assert property (pslverr |-> pready)
		else $error("error without ready");
endmodule

bind pmwc_top pmwc_assertions i_chk (.pclk, .presetn, .halt_req, .cpu_run, .wake_pulse,
	.pc_sp_reset, .irq_take, .sysclk_slow, .ls_osc_on, .sysclk_div_sel, .pready, .pslverr);

// ===== tb/pmwc_core_model.sv
/*
 Core model: issues a one-cycle halt pulse on request.
 Assumes go is driven at rising edges by the bench.
*/
`timescale 1ns/1ps
module pmwc_core_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic go,
	input wire logic cpu_run,
	output logic halt_req
);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			halt_req <= 1'h0;
		end else begin
			halt_req <= go && cpu_run && !halt_req;
		end
	end
endmodule

// ===== tb/pmwc_top_tb.sv
/*
 Self-checking bench for pmwc_top.
 Assumes the core model and the bound checker.
*/
`timescale 1ns/1ps
module pmwc_top_tb;
	import pmwc_pkg::*;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, go = 0;
	logic stack_full = 0, clr_wdt = 0, h, er;
	logic [7:0] paddr = 8'h00, porta_in = 8'hff, irq_req = 8'h00, irq_en = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, halt_req, cpu_run, sysclk_slow, hs_osc_on, ls_osc_on;
	logic wdt_overflow, pc_sp_reset, irq_take, wake_pulse;
	logic [2:0] sysclk_div_sel;
	int fails = 0, checked = 0, cyc = 0;
	always #10 pclk = ~pclk;
	pmwc_top #(.WDT_W(6)) i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .porta_in, .irq_req, .irq_en, .stack_full, .halt_req,
		.clr_wdt, .cpu_run, .sysclk_div_sel, .sysclk_slow, .hs_osc_on, .ls_osc_on,
		.wdt_overflow, .pc_sp_reset, .irq_take, .wake_pulse);
	pmwc_core_model i_core (.pclk, .presetn, .go, .cpu_run, .halt_req);
	task report_and_stop;
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			fails++;
			report_and_stop();
		end
	end
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do @(posedge pclk); while (pready !== 1'h1);
		rd = prdata;
		er = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task wt(input int n, input logic run, output logic hit);
		hit = 1'h0;
		for (int i = 0; i < n && !hit; i++) begin
			@(negedge pclk);
			hit = run ? cpu_run : wake_pulse;
		end
	endtask
	task do_halt;
		@(posedge pclk);
		go <= 1'h1;
		@(posedge pclk);
		go <= 1'h0;
		repeat (3) @(negedge pclk);
		chk(cpu_run, 32'h0);
	endtask
	task t_regs;
		repeat (70) @(posedge pclk);
		apb(1'h0, PMWC_ADDR_HSCTL, 32'h0);
		chk(rd, 32'h3);
		apb(1'h0, PMWC_ADDR_STATUS, 32'h0);
		chk(rd, 32'h18);
		apb(1'h0, 8'h20, 32'h0);
		chk({rd[30:0], er}, 32'h1);
	endtask
	task t_clk;
		apb(1'h1, PMWC_ADDR_CLKCTL, 32'he0);
		repeat (20) @(negedge pclk);
		chk(sysclk_slow, 32'h1);
		apb(1'h1, PMWC_ADDR_HSCTL, 32'h0);
		apb(1'h1, PMWC_ADDR_HSCTL, 32'h1);
		apb(1'h0, PMWC_ADDR_HSCTL, 32'h0);
		chk(rd, 32'h1);
		repeat (70) @(posedge pclk);
		for (int c = 6; c >= 0; c--) begin
			apb(1'h1, PMWC_ADDR_CLKCTL, 32'(c) << 5);
			repeat (2) @(negedge pclk);
			chk({sysclk_slow, sysclk_div_sel}, 32'(c));
		end
	endtask
	task t_modes;
		apb(1'h1, PMWC_ADDR_CMD, 32'h8);
		apb(1'h1, PMWC_ADDR_WAKEEN, 32'h1);
		for (int k = 0; k < 4; k++) begin
			apb(1'h1, PMWC_ADDR_CLKCTL, 32'(k));
			do_halt();
			chk({hs_osc_on, ls_osc_on}, 32'(k));
			@(posedge pclk);
			porta_in <= 8'hfe;
			wt(20, 1'h0, h);
			chk(h, 32'h1);
			@(posedge pclk);
			porta_in <= 8'hff;
			wt(100, 1'h1, h);
			chk(h, 32'h1);
			apb(1'h0, PMWC_ADDR_STATUS, 32'h0);
			chk(rd[2:1], 32'h1);
		end
		clr_wdt <= 1'h1;
		@(posedge pclk);
		clr_wdt <= 1'h0;
		apb(1'h0, PMWC_ADDR_STATUS, 32'h0);
		chk(rd[1], 32'h0);
	endtask
	task t_wdt;
		apb(1'h1, PMWC_ADDR_CLKCTL, 32'h0);
		apb(1'h1, PMWC_ADDR_CMD, 32'h4);
		h = 1'h0;
		repeat (70) begin
			@(negedge pclk);
			h = h | wdt_overflow;
		end
		chk(h, 32'h1);
		do_halt();
		chk(ls_osc_on, 32'h1);
		wt(50, 1'h0, h);
		chk(h, 32'h0);
		wt(40, 1'h0, h);
		chk({h, pc_sp_reset}, 32'h3);
		wt(100, 1'h1, h);
		apb(1'h1, PMWC_ADDR_CMD, 32'h8);
		apb(1'h0, PMWC_ADDR_STATUS, 32'h0);
		chk(rd[2:1], 32'h3);
	endtask
	task t_irq;
		for (int j = 0; j < 3; j++) begin
			@(posedge pclk);
			irq_req <= 8'h01;
			irq_en <= j == 1 ? 8'h00 : 8'h03;
			stack_full <= j == 2;
			do_halt();
			wt(40, 1'h0, h);
			chk(h, 32'h0);
			@(posedge pclk);
			irq_req <= 8'h03;
			wt(10, 1'h0, h);
			chk({h, irq_take}, j == 0 ? 32'h3 : 32'h2);
			wt(100, 1'h1, h);
		end
	endtask
	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1'h1;
		t_regs();
		t_clk();
		t_modes();
		t_wdt();
		t_irq();
		report_and_stop();
	end
endmodule
